// ---- shared/dct_pkg.sv ----
// Contract
// - Mode 3 splits first timer into bytes
// - Low byte uses first timer controls
// - High byte is timer only, never external
// - High byte uses second run, second flag
// - Second timer counts internally, never sets flag
// - Second timer runs unless mode is 3
// - Overflow flags set by hardware, cleared
// - Run/flag register bit layout, run enables
// - External flag set by edge or level
// - Type bit: 0 level, 1 edge
// - Mode register bit layout per timer
// - Gate bit adds gate input qualification
// - Counter-select picks clock or pin falls
// - Mode field decodes 13/16/8-reload/split
// - Prescale: 12, 4, 48, external/8
// - Clock choice: prescaled or system clock
// - Reload high-byte clock only when split
// - Reload low-byte clock select
// - External clock synchronised before dividing
// - 13-bit overflow at 0x1FFF sets flag
// - 8-bit reload from high byte
// - Run bit does not clear counts
package dct_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] RUN_FLAGS_OFFSET  = 8'h88;
  localparam logic [7:0] MODE_OFFSET       = 8'h89;
  localparam logic [7:0] FIRST_LOW_OFFSET  = 8'h8A;
  localparam logic [7:0] SECOND_LOW_OFFSET = 8'h8B;
  localparam logic [7:0] FIRST_HIGH_OFFSET = 8'h8C;
  localparam logic [7:0] SECOND_HIGH_OFFSET = 8'h8D;
  localparam logic [7:0] CLOCK_SEL_OFFSET  = 8'h8F;
  localparam logic [7:0] POLARITY_OFFSET   = 8'h90;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RUN_FLAGS_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET      = 8'h00;
  localparam logic [7:0] CLOCK_SEL_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET     = 8'h00;
  localparam logic [1:0] POLARITY_RESET  = 2'h0;

  // ==========================================================
  // Run and flags field positions
  localparam int SECOND_FLAG_BIT = 7;
  localparam int SECOND_RUN_BIT  = 6;
  localparam int FIRST_FLAG_BIT  = 5;
  localparam int FIRST_RUN_BIT   = 4;
  localparam int IRQ_B_FLAG_BIT  = 3;
  localparam int IRQ_B_TYPE_BIT  = 2;
  localparam int IRQ_A_FLAG_BIT  = 1;
  localparam int IRQ_A_TYPE_BIT  = 0;

  // Mode register field positions
  localparam int SECOND_GATE_BIT  = 7;
  localparam int SECOND_CSEL_BIT  = 6;
  localparam int SECOND_MODE_LSB  = 4;
  localparam int FIRST_GATE_BIT   = 3;
  localparam int FIRST_CSEL_BIT   = 2;
  localparam int FIRST_MODE_LSB   = 0;

  // Clock select field positions
  localparam int RELOAD_B_HIGH_BIT = 7;
  localparam int RELOAD_B_LOW_BIT  = 6;
  localparam int RELOAD_A_HIGH_BIT = 5;
  localparam int RELOAD_A_LOW_BIT  = 4;
  localparam int SECOND_CLOCK_BIT  = 3;
  localparam int FIRST_CLOCK_BIT   = 2;
  localparam int PRESCALE_LSB      = 0;

  // ==========================================================
  // Divider counts, pin gap and counter limits
  localparam logic [3:0] DIV12_LAST  = 4'hB;
  localparam logic [1:0] DIV4_LAST   = 2'h3;
  localparam logic [5:0] DIV48_LAST  = 6'h2F;
  localparam logic [2:0] EXT_DIV_LAST = 3'h7;
  localparam logic [1:0] PIN_GAP_LAST = 2'h3;
  localparam logic [4:0] LOW5_ONES   = 5'h1F;
  localparam logic [7:0] BYTE_ONES   = 8'hFF;

  typedef enum logic [1:0] {
    MODE_13BIT  = 2'b00,
    MODE_16BIT  = 2'b01,
    MODE_RELOAD = 2'b10,
    MODE_SPLIT  = 2'b11
  } dct_mode_e;

  typedef enum logic [1:0] {
    PRE_DIV12 = 2'b00,
    PRE_DIV4  = 2'b01,
    PRE_DIV48 = 2'b10,
    PRE_EXT8  = 2'b11
  } dct_prescale_e;

endpackage

// ---- verilog/dct_timer_control.sv ----
`timescale 1ns/1ps
module dct_timer_control (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output logic      [7:0] regRdata,
  input  wire logic       gateInputA,
  input  wire logic       gateInputB,
  input  wire logic       countPinA,
  input  wire logic       countPinB,
  input  wire logic       extClk,
  input  wire logic       ackFirstTimer,
  input  wire logic       ackSecondTimer,
  input  wire logic       ackIrqA,
  input  wire logic       ackIrqB,
  input  wire logic       reloadTimerAExtSelect,
  input  wire logic       reloadTimerBExtSelect,
  input  wire logic       reloadTimerASplit,
  input  wire logic       reloadTimerBSplit,
  output logic            reloadTimerALowTick,
  output logic            reloadTimerAHighTick,
  output logic            reloadTimerBLowTick,
  output logic            reloadTimerBHighTick,
  output logic            secondOverflowPulse,
  output logic            firstTimerIrq,
  output logic            secondTimerIrq,
  output logic            extIrqA,
  output logic            extIrqB
);

  // ==========================================================
  // Registers
  logic [7:0] runFlags_q;
  logic [7:0] runFlags_d;
  logic [7:0] mode_q;
  logic [7:0] clkSel_q;
  logic [1:0] polarity_q;
  logic [7:0] firstLow_q;
  logic [7:0] firstLow_d;
  logic [7:0] firstHigh_q;
  logic [7:0] firstHigh_d;
  logic [7:0] secondLow_q;
  logic [7:0] secondLow_d;
  logic [7:0] secondHigh_q;
  logic [7:0] secondHigh_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       secondOvf_q;

  // ==========================================================
  // Bus decode
  wire wrRunFlags = regWrite && regAddr == dct_pkg::RUN_FLAGS_OFFSET;
  wire wrMode     = regWrite && regAddr == dct_pkg::MODE_OFFSET;
  wire wrClkSel   = regWrite && regAddr == dct_pkg::CLOCK_SEL_OFFSET;
  wire wrPolarity = regWrite && regAddr == dct_pkg::POLARITY_OFFSET;
  wire wrFirstLo  = regWrite && regAddr == dct_pkg::FIRST_LOW_OFFSET;
  wire wrFirstHi  = regWrite && regAddr == dct_pkg::FIRST_HIGH_OFFSET;
  wire wrSecondLo = regWrite && regAddr == dct_pkg::SECOND_LOW_OFFSET;
  wire wrSecondHi = regWrite && regAddr == dct_pkg::SECOND_HIGH_OFFSET;

  // ==========================================================
  // Field decode
  wire                secondRun    = runFlags_q[dct_pkg::SECOND_RUN_BIT];
  wire                firstRun     = runFlags_q[dct_pkg::FIRST_RUN_BIT];
  wire                irqBType     = runFlags_q[dct_pkg::IRQ_B_TYPE_BIT];
  wire                irqAType     = runFlags_q[dct_pkg::IRQ_A_TYPE_BIT];
  wire                secondGate   = mode_q[dct_pkg::SECOND_GATE_BIT];
  wire                secondCsel   = mode_q[dct_pkg::SECOND_CSEL_BIT];
  wire                firstGate    = mode_q[dct_pkg::FIRST_GATE_BIT];
  wire                firstCsel    = mode_q[dct_pkg::FIRST_CSEL_BIT];
  wire dct_pkg::dct_mode_e secondMode =
    dct_pkg::dct_mode_e'(mode_q[dct_pkg::SECOND_MODE_LSB +: 2]);
  wire dct_pkg::dct_mode_e firstMode =
    dct_pkg::dct_mode_e'(mode_q[dct_pkg::FIRST_MODE_LSB +: 2]);
  wire dct_pkg::dct_prescale_e prescale =
    dct_pkg::dct_prescale_e'(clkSel_q[dct_pkg::PRESCALE_LSB +: 2]);
  wire firstSplit = firstMode == dct_pkg::MODE_SPLIT;

  // ==========================================================
  // Prescaler
  logic [3:0] div12_q;
  logic [1:0] div4_q;
  logic [5:0] div48_q;
  wire        div12Tick = div12_q == dct_pkg::DIV12_LAST;
  wire        div4Tick  = div4_q == dct_pkg::DIV4_LAST;
  wire        div48Tick = div48_q == dct_pkg::DIV48_LAST;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div12_q <= 4'h0;
      div4_q  <= 2'h0;
      div48_q <= 6'h00;
    end else begin
      div12_q <= div12Tick ? 4'h0 : div12_q + 4'h1;
      div4_q  <= div4_q + 2'h1;
      div48_q <= div48Tick ? 6'h00 : div48_q + 6'h01;
    end
  end

  // External clock: the first stage feeds only the second. Edges are lost
  // if the external clock runs faster than half the system clock.
  logic       extSync1_q;
  logic       extSync2_q;
  logic       extSync3_q;
  logic [2:0] extDiv_q;
  wire        extRise  = extSync2_q && !extSync3_q;
  wire        ext8Tick = extRise && extDiv_q == dct_pkg::EXT_DIV_LAST;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      extSync1_q <= 1'b0;
      extSync2_q <= 1'b0;
      extSync3_q <= 1'b0;
      extDiv_q   <= 3'h0;
    end else begin
      extSync1_q <= extClk;
      extSync2_q <= extSync1_q;
      extSync3_q <= extSync2_q;
      if (extRise) begin
        extDiv_q <= extDiv_q + 3'h1;
      end
    end
  end

  logic preTick;
  always_comb begin
    unique case (prescale)
      dct_pkg::PRE_DIV12: preTick = div12Tick;
      dct_pkg::PRE_DIV4:  preTick = div4Tick;
      dct_pkg::PRE_DIV48: preTick = div48Tick;
      dct_pkg::PRE_EXT8:  preTick = ext8Tick;
    endcase
  end

  // ==========================================================
  // Reload timer clock selects
  // External choice comes from each reload timer's own select pin
  wire [1:0] relExtSel = {reloadTimerBExtSelect, reloadTimerAExtSelect};
  wire [1:0] relSplit  = {reloadTimerBSplit, reloadTimerASplit};
  wire [1:0] relLowBit = {clkSel_q[dct_pkg::RELOAD_B_LOW_BIT],
                          clkSel_q[dct_pkg::RELOAD_A_LOW_BIT]};
  wire [1:0] relHiBit  = {clkSel_q[dct_pkg::RELOAD_B_HIGH_BIT],
                          clkSel_q[dct_pkg::RELOAD_A_HIGH_BIT]};
  logic [1:0] relLowTick;
  logic [1:0] relHighTick;

  genvar r;
  generate
    for (r = 0; r < 2; r++) begin : gReload
      wire choice = relExtSel[r] ? ext8Tick : div12Tick;
      assign relLowTick[r]  = relLowBit[r] ? 1'b1 : choice;
      assign relHighTick[r] = relSplit[r] && (relHiBit[r] ? 1'b1 : choice);
    end
  endgenerate

  assign reloadTimerALowTick  = relLowTick[0];
  assign reloadTimerBLowTick  = relLowTick[1];
  assign reloadTimerAHighTick = relHighTick[0];
  assign reloadTimerBHighTick = relHighTick[1];

  // ==========================================================
  // Pins: index 0 is the first timer / irq A, index 1 the second / irq B
  wire [1:0] countPins = {countPinB, countPinA};
  wire [1:0] gatePins  = {gateInputB, gateInputA};
  logic [1:0] pinFall;
  logic [1:0] gateActive;
  logic [1:0] gateRise;

  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : gPins
      logic       pinNow_q;
      logic       pinOld_q;
      logic [1:0] gap_q;
      logic       actOld_q;
      wire        act = polarity_q[p] ? gatePins[p] : !gatePins[p];
      assign pinFall[p]    = pinOld_q && !pinNow_q && gap_q == 2'h0;
      assign gateActive[p] = act;
      assign gateRise[p]   = act && !actOld_q;
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          pinNow_q <= 1'b0;
          pinOld_q <= 1'b0;
          gap_q    <= 2'h0;
          actOld_q <= 1'b0;
        end else begin
          pinNow_q <= countPins[p];
          pinOld_q <= pinNow_q;
          actOld_q <= act;
          if (pinFall[p]) begin
            gap_q <= dct_pkg::PIN_GAP_LAST;
          end else if (gap_q != 2'h0) begin
            gap_q <= gap_q - 2'h1;
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // Enables and ticks
  wire firstEn  = firstRun && (!firstGate || gateActive[0]);
  wire firstTick = firstCsel ? pinFall[0]
                 : (clkSel_q[dct_pkg::FIRST_CLOCK_BIT] ? 1'b1 : preTick);
  wire splitHighTick = clkSel_q[dct_pkg::FIRST_CLOCK_BIT] ? 1'b1 : preTick;
  wire secondEn = firstSplit ? secondMode != dct_pkg::MODE_SPLIT
                : secondRun && (!secondGate || gateActive[1])
                  && secondMode != dct_pkg::MODE_SPLIT;
  wire secondTick = (secondCsel && !firstSplit) ? pinFall[1]
                  : (clkSel_q[dct_pkg::SECOND_CLOCK_BIT] ? 1'b1 : preTick);

  // Counting step for modes 0 to 2; returns {overflow, high, low}
  function automatic logic [16:0] stepCount(input logic [1:0] md,
                                            input logic [7:0] hi,
                                            input logic [7:0] lo);
    logic [16:0] res;
    res = {1'b0, hi, lo};
    case (md)
      dct_pkg::MODE_13BIT: begin
        if (lo[4:0] == dct_pkg::LOW5_ONES) begin
          res = {hi == dct_pkg::BYTE_ONES, hi + 8'h01, lo[7:5], 5'h00};
        end else begin
          res = {1'b0, hi, lo[7:5], lo[4:0] + 5'h01};
        end
      end
      dct_pkg::MODE_16BIT: begin
        res = {1'b0, hi, lo} + 17'h00001;
      end
      dct_pkg::MODE_RELOAD: begin
        res = (lo == dct_pkg::BYTE_ONES) ? {1'b1, hi, hi} : {1'b0, hi, lo + 8'h01};
      end
      default: begin
        res = {1'b0, hi, lo};
      end
    endcase
    return res;
  endfunction

  // ==========================================================
  // Count next values; counts only move while enabled
  logic firstOvf;
  logic secondOvf;
  logic splitHighOvf;
  logic [16:0] firstStep;
  logic [16:0] secondStep;

  always_comb begin
    firstStep    = stepCount(firstMode, firstHigh_q, firstLow_q);
    secondStep   = stepCount(secondMode, secondHigh_q, secondLow_q);
    firstLow_d   = firstLow_q;
    firstHigh_d  = firstHigh_q;
    secondLow_d  = secondLow_q;
    secondHigh_d = secondHigh_q;
    firstOvf     = 1'b0;
    secondOvf    = 1'b0;
    splitHighOvf = 1'b0;
    if (firstSplit) begin
      if (firstEn && firstTick) begin
        firstLow_d = firstLow_q + 8'h01;
        firstOvf   = firstLow_q == dct_pkg::BYTE_ONES;
      end
      if (secondRun && splitHighTick) begin
        firstHigh_d  = firstHigh_q + 8'h01;
        splitHighOvf = firstHigh_q == dct_pkg::BYTE_ONES;
      end
    end else if (firstEn && firstTick) begin
      {firstOvf, firstHigh_d, firstLow_d} = firstStep;
    end
    if (secondEn && secondTick) begin
      {secondOvf, secondHigh_d, secondLow_d} = secondStep;
    end
  end

  // ==========================================================
  // Flags: hardware set wins over software or vector clear
  wire [7:0] flagBase = wrRunFlags ? regWdata : runFlags_q;
  wire secondSet = splitHighOvf || (secondOvf && !firstSplit);
  wire irqASet   = irqAType ? gateRise[0] : gateActive[0];
  wire irqBSet   = irqBType ? gateRise[1] : gateActive[1];

  always_comb begin
    runFlags_d = flagBase;
    runFlags_d[dct_pkg::SECOND_FLAG_BIT] = secondSet
      || (flagBase[dct_pkg::SECOND_FLAG_BIT] && !ackSecondTimer);
    runFlags_d[dct_pkg::FIRST_FLAG_BIT] = firstOvf
      || (flagBase[dct_pkg::FIRST_FLAG_BIT] && !ackFirstTimer);
    runFlags_d[dct_pkg::IRQ_A_FLAG_BIT] = irqAType
      ? irqASet || (flagBase[dct_pkg::IRQ_A_FLAG_BIT] && !ackIrqA)
      : irqASet;
    runFlags_d[dct_pkg::IRQ_B_FLAG_BIT] = irqBType
      ? irqBSet || (flagBase[dct_pkg::IRQ_B_FLAG_BIT] && !ackIrqB)
      : irqBSet;
  end

  // ==========================================================
  // Register storage
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      runFlags_q   <= dct_pkg::RUN_FLAGS_RESET;
      mode_q       <= dct_pkg::MODE_RESET;
      clkSel_q     <= dct_pkg::CLOCK_SEL_RESET;
      polarity_q   <= dct_pkg::POLARITY_RESET;
      firstLow_q   <= dct_pkg::COUNT_RESET;
      firstHigh_q  <= dct_pkg::COUNT_RESET;
      secondLow_q  <= dct_pkg::COUNT_RESET;
      secondHigh_q <= dct_pkg::COUNT_RESET;
      secondOvf_q  <= 1'b0;
    end else begin
      runFlags_q   <= runFlags_d;
      mode_q       <= wrMode ? regWdata : mode_q;
      clkSel_q     <= wrClkSel ? regWdata : clkSel_q;
      polarity_q   <= wrPolarity ? regWdata[1:0] : polarity_q;
      // A software write to a count byte beats the same-cycle increment
      firstLow_q   <= wrFirstLo ? regWdata : firstLow_d;
      firstHigh_q  <= wrFirstHi ? regWdata : firstHigh_d;
      secondLow_q  <= wrSecondLo ? regWdata : secondLow_d;
      secondHigh_q <= wrSecondHi ? regWdata : secondHigh_d;
      secondOvf_q  <= secondOvf;
    end
  end

  // ==========================================================
  // Read port
  always_comb begin
    unique case (regAddr)
      dct_pkg::RUN_FLAGS_OFFSET:   rdata_d = runFlags_q;
      dct_pkg::MODE_OFFSET:        rdata_d = mode_q;
      dct_pkg::CLOCK_SEL_OFFSET:   rdata_d = clkSel_q;
      dct_pkg::POLARITY_OFFSET:    rdata_d = {6'h00, polarity_q};
      dct_pkg::FIRST_LOW_OFFSET:   rdata_d = firstLow_q;
      dct_pkg::FIRST_HIGH_OFFSET:  rdata_d = firstHigh_q;
      dct_pkg::SECOND_LOW_OFFSET:  rdata_d = secondLow_q;
      dct_pkg::SECOND_HIGH_OFFSET: rdata_d = secondHigh_q;
      default:                     rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= regRead ? rdata_d : 8'h00;
    end
  end

  assign regRdata            = rdata_q;
  assign secondOverflowPulse = secondOvf_q;
  assign firstTimerIrq       = runFlags_q[dct_pkg::FIRST_FLAG_BIT];
  assign secondTimerIrq      = runFlags_q[dct_pkg::SECOND_FLAG_BIT];
  assign extIrqA             = runFlags_q[dct_pkg::IRQ_A_FLAG_BIT];
  assign extIrqB             = runFlags_q[dct_pkg::IRQ_B_FLAG_BIT];

endmodule

// ---- verification/dct_pin_model.sv ----
`timescale 1ns/1ps
module dct_pin_model (
  input  wire logic       clk,
  input  wire logic [1:0] fallReq,
  input  wire logic [1:0] gateLevel,
  output logic            countPinA,
  output logic            countPinB,
  output logic            gateInputA,
  output logic            gateInputB,
  output logic            extClk
);
  // ==========================================================
  // Count pins: each requested fall holds low two clocks
  logic [1:0] lowA = 2'h0;
  logic [1:0] lowB = 2'h0;
  always_ff @(posedge clk) begin
    lowA <= fallReq[0] ? 2'h2 : lowA - (lowA != 2'h0);
    lowB <= fallReq[1] ? 2'h2 : lowB - (lowB != 2'h0);
  end
  assign countPinA  = (lowA == 2'h0);
  assign countPinB  = (lowB == 2'h0);
  assign gateInputA = gateLevel[0];
  assign gateInputB = gateLevel[1];
  // ==========================================================
  // Free-running oscillator, slower than clk and out of phase
  initial begin
    extClk = 1'b0;
    #37;
    forever #115 extClk = ~extClk;
  end
endmodule

// ---- verification/dct_timer_control_checker.sv ----
`timescale 1ns/1ps
module dct_timer_control_checker (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [7:0] regRdata,
  input wire logic       gateInputA,
  input wire logic       gateInputB,
  input wire logic       ackIrqA,
  input wire logic       reloadTimerAExtSelect,
  input wire logic       reloadTimerASplit,
  input wire logic       reloadTimerBSplit,
  input wire logic       reloadTimerALowTick,
  input wire logic       reloadTimerAHighTick,
  input wire logic       reloadTimerBHighTick,
  input wire logic       extIrqA,
  input wire logic       extIrqB
);
  // ==========================================================
  // Shadow of software-written fields
  logic [7:0] modeQ;
  logic [7:0] ckQ;
  logic [1:0] typeQ;
  logic [1:0] polQ;
  wire        wrRun  = regWrite && regAddr == dct_pkg::RUN_FLAGS_OFFSET;
  wire        wrMode = regWrite && regAddr == dct_pkg::MODE_OFFSET;
  wire        wrCk   = regWrite && regAddr == dct_pkg::CLOCK_SEL_OFFSET;
  wire        wrPol  = regWrite && regAddr == dct_pkg::POLARITY_OFFSET;
  wire        noClrA = !ackIrqA && !wrRun;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      modeQ <= dct_pkg::MODE_RESET;
      ckQ   <= dct_pkg::CLOCK_SEL_RESET;
      typeQ <= 2'h0;
      polQ  <= dct_pkg::POLARITY_RESET;
    end else begin
      modeQ <= wrMode ? regWdata : modeQ;
      ckQ   <= wrCk ? regWdata : ckQ;
      typeQ <= wrRun ? {regWdata[2], regWdata[0]} : typeQ;
      polQ  <= wrPol ? regWdata[1:0] : polQ;
    end
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_rdata_idle: assert property (!$past(regRead) |-> regRdata == 8'h00)
    else $error("read data not zero outside answer cycle");
  a_mode_readback: assert property (regRead && regAddr == dct_pkg::MODE_OFFSET |=>
    regRdata == $past(modeQ)) else $error("mode register read back wrong");
  a_clock_readback: assert property (regRead && regAddr == dct_pkg::CLOCK_SEL_OFFSET |=>
    regRdata == $past(ckQ)) else $error("clock select read back wrong");
  a_level_a_set: assert property ((!typeQ[0] && gateInputA == polQ[0])[*3] |-> extIrqA)
    else $error("level irq A not following active input");
  a_level_b_clear: assert property ((!typeQ[1] && gateInputB != polQ[1])[*3] |-> !extIrqB)
    else $error("level irq B high while input inactive");
  a_edge_a_hold: assert property ((typeQ[0] && noClrA)[*2] ##0 extIrqA ##1
    (typeQ[0] && noClrA) |=> extIrqA) else $error("edge irq A lost without clear");
  a_high_tick_a: assert property (!reloadTimerASplit |-> !reloadTimerAHighTick)
    else $error("high tick A outside split mode");
  a_high_tick_b: assert property (!reloadTimerBSplit |-> !reloadTimerBHighTick)
    else $error("high tick B outside split mode");
  a_low_tick_sys: assert property (ckQ[4] |-> reloadTimerALowTick)
    else $error("low tick A missing with system clock");
  a_low_tick_div: assert property ((!ckQ[4] && reloadTimerALowTick) ##1
    (!ckQ[4] && $stable(reloadTimerAExtSelect)) |-> !reloadTimerALowTick)
    else $error("divided low tick A on two cycles running");
  c_edge_a: cover property ($rose(extIrqA));
  c_level_b: cover property ($rose(extIrqB));
  c_high_tick_b: cover property (reloadTimerBHighTick);
endmodule

bind dct_timer_control dct_timer_control_checker chk_u (
  .clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWdata(regWdata),
  .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
  .gateInputA(gateInputA), .gateInputB(gateInputB), .ackIrqA(ackIrqA),
  .reloadTimerAExtSelect(reloadTimerAExtSelect), .reloadTimerASplit(reloadTimerASplit),
  .reloadTimerBSplit(reloadTimerBSplit), .reloadTimerALowTick(reloadTimerALowTick),
  .reloadTimerAHighTick(reloadTimerAHighTick), .reloadTimerBHighTick(reloadTimerBHighTick),
  .extIrqA(extIrqA), .extIrqB(extIrqB)
);

// ---- verification/dct_timer_control_tb_top.sv ----
`timescale 1ns/1ps
module dct_timer_control_tb_top;
  localparam logic [7:0] RUNF = dct_pkg::RUN_FLAGS_OFFSET;
  localparam logic [7:0] MODE = dct_pkg::MODE_OFFSET;
  localparam logic [7:0] CKS  = dct_pkg::CLOCK_SEL_OFFSET;
  localparam logic [7:0] FLO  = dct_pkg::FIRST_LOW_OFFSET;
  localparam logic [7:0] FHI  = dct_pkg::FIRST_HIGH_OFFSET;
  localparam logic [7:0] SLO  = dct_pkg::SECOND_LOW_OFFSET;
  localparam logic [7:0] SHI  = dct_pkg::SECOND_HIGH_OFFSET;
  localparam logic [7:0] POL  = dct_pkg::POLARITY_OFFSET;
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic       regWrite = 1'b0;
  logic       regRead = 1'b0;
  logic       ackT1 = 1'b0, ackT2 = 1'b0, ackA = 1'b0;
  logic       extSel = 1'b0, splitA = 1'b0, splitB = 1'b0;
  logic [1:0] fallReq = 2'h0;
  logic [1:0] gateLevel = 2'h0;
  logic [7:0] regRdata;
  logic [7:0] d;
  logic       pinA, pinB, gateA, gateB, extClk, ovfPulse, t1Irq, t2Irq, extIrqA, extIrqB;
  int         n_errors = 0, n_compared = 0, seed = 70022, nPulse = 0, k;
  logic [7:0] pre [5] = '{8'd33, 8'd66, 8'd20, 8'd27, 8'd216};
  logic [7:0] sm [3] = '{8'h27, 8'h67, 8'h37};
  logic [7:0] plo [3] = '{8'd8, 8'd8, 8'd0};
  logic [7:0] phi [3] = '{8'd12, 8'd12, 8'd0};

  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    splitA <= 1'($random(seed));
    splitB <= 1'($random(seed));
    nPulse <= nPulse + int'(ovfPulse === 1'b1);
  end

  dct_pin_model pin_u (.clk(clk), .fallReq(fallReq), .gateLevel(gateLevel),
    .countPinA(pinA), .countPinB(pinB), .gateInputA(gateA), .gateInputB(gateB),
    .extClk(extClk));
  dct_timer_control dut_u (.clk(clk), .reset_n(reset_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .gateInputA(gateA), .gateInputB(gateB), .countPinA(pinA), .countPinB(pinB),
    .extClk(extClk), .ackFirstTimer(ackT1), .ackSecondTimer(ackT2), .ackIrqA(ackA),
    .ackIrqB(1'b0), .reloadTimerAExtSelect(extSel), .reloadTimerBExtSelect(extSel),
    .reloadTimerASplit(splitA), .reloadTimerBSplit(splitB), .reloadTimerALowTick(),
    .reloadTimerAHighTick(), .reloadTimerBLowTick(), .reloadTimerBHighTick(),
    .secondOverflowPulse(ovfPulse), .firstTimerIrq(t1Irq), .secondTimerIrq(t2Irq),
    .extIrqA(extIrqA), .extIrqB(extIrqB));

  // ==========================================================
  // Bus and check tasks
  task automatic end_sim();
    $display("Compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
    n_compared++;
    if ($isunknown(got) || got < lo || got > hi) begin
      $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      n_errors++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr  <= a;
    regWdata <= v;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    chk(regRdata, lo, hi);
  endtask
  task automatic falls(input int w, input int n);
    repeat (n) begin
      @(posedge clk);
      fallReq[w] <= 1'b1;
      @(posedge clk);
      fallReq[w] <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
  task automatic ovf(input logic [7:0] m, input logic [7:0] th, input logic [7:0] tl);
    wr(MODE, m);
    wr(FHI, th);
    wr(FLO, tl);
    wr(RUNF, 8'h10);
    for (k = 0; k < 20 && t1Irq !== 1'b1; k++) @(posedge clk) #1;
    chk(8'(t1Irq), 8'h01, 8'h01);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    rdc(RUNF, 8'h0A, 8'h0A);
    rdc(MODE, 8'h00, 8'h00);
    rdc(CKS, 8'h00, 8'h00);
    rdc(8'h80, 8'h00, 8'h00);
    repeat (4) begin
      d = 8'($random(seed));
      wr(MODE, d);
      rdc(MODE, d, d);
      wr(CKS, d);
      rdc(CKS, d, d);
    end
    wr(MODE, 8'h01);
    for (int p = 0; p < 5; p++) begin
      @(posedge clk);
      extSel <= (p == 3);
      wr(CKS, (p == 4) ? 8'h04 : 8'(p));
      wr(FLO, 8'h10);
      wr(RUNF, 8'h10);
      repeat (198) @(posedge clk);
      wr(RUNF, 8'h00);
      rdc(FLO, pre[p] - 8'd2, pre[p] + 8'd2);
    end
    wr(CKS, 8'h04);
    ovf(8'h00, 8'hFF, 8'h1D);
    @(posedge clk);
    ackT1 <= 1'b1;
    @(posedge clk);
    ackT1 <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk(8'(t1Irq), 8'h00, 8'h00);
    wr(RUNF, 8'h00);
    rdc(FHI, 8'h00, 8'h00);
    ovf(8'h02, 8'hF0, 8'hFD);
    wr(RUNF, 8'h00);
    rdc(FLO, 8'hF0, 8'hF8);
    rdc(FHI, 8'hF0, 8'hF0);
    rdc(RUNF, 8'h0A, 8'h0A);
    wr(CKS, 8'h0C);
    wr(SLO, 8'hFC);
    wr(SHI, 8'hFC);
    ovf(8'h23, 8'hFE, 8'hFD);
    wr(RUNF, 8'h40);
    for (k = 0; k < 20 && t2Irq !== 1'b1; k++) @(posedge clk) #1;
    chk(8'(t2Irq), 8'h01, 8'h01);
    @(posedge clk) ackT2 <= 1'b1;
    @(posedge clk) ackT2 <= 1'b0;
    #1 chk(8'(t2Irq), 8'h00, 8'h00);
    rdc(FLO, 8'h00, 8'h08);
    wr(MODE, 8'h27);
    wr(FHI, 8'h00);
    repeat (18) @(posedge clk);
    wr(RUNF, 8'h00);
    rdc(FHI, 8'd17, 8'd23);
    foreach (sm[i]) begin
      wr(MODE, sm[i]);
      @(posedge clk) #1 k = nPulse;
      repeat (40) @(posedge clk);
      #1 chk(8'(nPulse - k), plo[i], phi[i]);
    end
    chk(8'(t2Irq), 8'h00, 8'h00);
    wr(MODE, 8'h5D);
    wr(POL, 8'h03);
    wr(FLO, 8'h00);
    wr(SLO, 8'h00);
    wr(RUNF, 8'h50);
    falls(0, 3);
    rdc(FLO, 8'h00, 8'h00);
    @(posedge clk);
    gateLevel <= 2'h1;
    falls(0, 10);
    falls(1, 3);
    rdc(FLO, 8'd10, 8'd10);
    rdc(SLO, 8'd3, 8'd3);
    wr(RUNF, 8'h05);
    @(posedge clk);
    gateLevel <= 2'h0;
    @(posedge clk);
    gateLevel <= 2'h1;
    repeat (3) @(posedge clk);
    #1 chk(8'(extIrqA), 8'h01, 8'h01);
    rdc(RUNF, 8'h07, 8'h07);
    @(posedge clk);
    ackA <= 1'b1;
    @(posedge clk);
    ackA <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk(8'(extIrqA), 8'h00, 8'h00);
    wr(RUNF, 8'h00);
    repeat (3) @(posedge clk);
    #1 chk(8'(extIrqA), 8'h01, 8'h01);
    wr(POL, 8'h00);
    repeat (3) @(posedge clk);
    #1 chk(8'(extIrqA), 8'h00, 8'h00);
    chk(8'(extIrqB), 8'h01, 8'h01);
    end_sim();
  end
endmodule
